// [bench/prd_agent.sv]
// Purpose : Chipset and core agents issuing checked accesses
// Assumes : One access at a time, driven on the falling edge
// Notes   : Idle address lines show the inverse of the last value
module prd_agent
   import prd_pkg::*;
(
   input  wire logic                  core_clk,
   output logic                       chipReq,
   output logic      [PRD_ADDR_W-1:0] chipAddr,
   input  wire logic                  chipDone,
   input  wire logic                  chipAbort,
   input  wire logic                  machineCheck,
   output logic                       coreReq,
   output logic      [PRD_ADDR_W-1:0] coreAddr,
   input  wire logic                  coreDone,
   input  wire logic                  coreAbort
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      chipReq  = 1'b0;
      coreReq  = 1'b0;
      chipAddr = 40'h00_0000_0000;
      coreAddr = 40'hFF_FFFF_FFFF;
   end

   ////////////////////////////////////////////////////////////////////////
   // A gap before the request lets the bench play a slow requester
   task automatic access(input logic isCore, input logic [39:0] a,
                         input int gap, output logic d, output logic ab,
                         output logic mc);
      repeat (gap) @(negedge core_clk);
      @(negedge core_clk);
      if (isCore)
      begin
         coreReq  = 1'b1;
         coreAddr = a;
      end
      else
      begin
         chipReq  = 1'b1;
         chipAddr = a;
      end
      @(negedge core_clk);
      d        = isCore ? coreDone : chipDone;
      ab       = isCore ? coreAbort : chipAbort;
      mc       = machineCheck;
      coreReq  = 1'b0;
      chipReq  = 1'b0;
      coreAddr = ~coreAddr;
      chipAddr = ~chipAddr;
   endtask : access
endmodule : prd_agent

// [bench/test_protected_range_decoder.sv]
// Purpose : Self-checking bench for the protected range decoder
// Assumes : Fixed seed, inputs driven on the falling edge
// Notes   : Expected register images are kept here, never read back
module test_protected_range_decoder
   import prd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [63:0] BASE_BITS = 64'h0000_00FF_FFF8_0000;
   localparam logic [63:0] MASK_BITS = 64'h0000_00FF_FFF8_0C00;

   logic        core_clk  = 1'b0;
   logic        rst_n     = 1'b0;
   logic        cfgReq    = 1'b0;
   logic        cfgWrite  = 1'b0;
   logic [7:0]  cfgOffset = 8'h00;
   logic [63:0] cfgWdata  = 64'h0000_0000_0000_0000;
   logic        cfgAck, chipReq, chipDone, chipAbort, machineCheck;
   logic        coreReq, coreDone, coreAbort;
   logic [63:0] cfgRdata;
   logic [39:0] chipAddr, coreAddr;
   logic [63:0] expReg [4];
   int          error_cnt   = 0;
   int          check_count = 0;

   always #5 core_clk = ~core_clk;

   prd_decoder i_dut (.core_clk(core_clk), .rst_n(rst_n), .cfgReq(cfgReq),
      .cfgWrite(cfgWrite), .cfgOffset(cfgOffset), .cfgWdata(cfgWdata),
      .cfgAck(cfgAck), .cfgRdata(cfgRdata), .chipReq(chipReq),
      .chipAddr(chipAddr), .chipDone(chipDone), .chipAbort(chipAbort),
      .machineCheck(machineCheck), .coreReq(coreReq), .coreAddr(coreAddr),
      .coreDone(coreDone), .coreAbort(coreAbort));

   prd_agent i_agent (.core_clk(core_clk), .chipReq(chipReq),
      .chipAddr(chipAddr), .chipDone(chipDone), .chipAbort(chipAbort),
      .machineCheck(machineCheck), .coreReq(coreReq), .coreAddr(coreAddr),
      .coreDone(coreDone), .coreAbort(coreAbort));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic isHit(int s, logic [39:0] a);
      logic [63:0] b;
      logic [63:0] m;
      b = expReg[2*s];
      m = expReg[2*s+1];
      return m[PRD_ENABLE_B] && (((a[39:19] ^ b[39:19]) & m[39:19]) == 0);
   endfunction : isHit

   function automatic logic [63:0] expRead(logic [7:0] off);
      if (off inside {8'h60, 8'h68, 8'h70, 8'h78})
         return expReg[off[4:3]];
      return 64'h0000_0000_0000_0000;
   endfunction : expRead

   task automatic chk(string name, logic [63:0] exp, logic [63:0] got);
      check_count++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
         error_cnt++;
      end
   endtask : chk

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict

   task automatic do_reset();
      @(negedge core_clk);
      rst_n = 1'b0;
      repeat (4) @(negedge core_clk);
      rst_n = 1'b1;
      foreach (expReg[i]) expReg[i] = 64'h0000_0000_0000_0000;
   endtask : do_reset

   ////////////////////////////////////////////////////////////////////////
   // Locked writes only leave the image alone after the answer is checked
   task automatic cfg(logic wr, logic [7:0] off, logic [63:0] wd);
      logic [63:0] rd;
      logic [1:0]  idx;
      @(negedge core_clk);
      cfgReq    = 1'b1;
      cfgWrite  = wr;
      cfgOffset = off;
      cfgWdata  = wd;
      @(negedge core_clk);
      chk("cfgAck", 64'h1, 64'(cfgAck));
      rd     = cfgRdata;
      cfgReq = 1'b0;
      chk("cfgRdata", wr ? 64'h0 : expRead(off), rd);
      idx = off[4:3];
      if (wr && off inside {8'h60, 8'h68, 8'h70, 8'h78} &&
          !expReg[2*idx[1]+1][PRD_LOCK_B])
         expReg[idx] = wd & (idx[0] ? MASK_BITS : BASE_BITS);
   endtask : cfg

   task automatic acc(logic isCore, logic [39:0] a);
      logic d;
      logic ab;
      logic mc;
      logic e;
      e = isCore ? isHit(1, a) : isHit(0, a);
      i_agent.access(isCore, a, $urandom % 3, d, ab, mc);
      chk("done", 64'h1, 64'(d));
      chk("abort", 64'(e), 64'(ab));
      chk("machineCheck", 64'(!isCore && e), 64'(mc));
   endtask : acc

   // Programs a power-of-two range, then probes both edges from both sides
   task automatic seg_run(int s, logic [39:0] b, logic [39:0] sz);
      logic [39:0] offs [4];
      offs = '{40'h0, sz - 40'h1, sz, -40'h1};
      cfg(1'b1, 8'h60 + 8'(16*s), {24'h0, b});
      cfg(1'b1, 8'h68 + 8'(16*s),
          ({24'h0, ~(sz - 40'h1)} & BASE_BITS) | 64'h800);
      foreach (offs[i])
      begin
         acc(1'b0, b + offs[i]);
         acc(1'b1, b + offs[i]);
      end
   endtask : seg_run

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [63:0] r;
      logic [39:0] b;
      logic [39:0] sz;
      int          s;
      void'($urandom(85));
      do_reset();
      for (int k = 0; k < 6; k++) cfg(1'b0, 8'h58 + 8'(8*k), '0);
      $display("test reset_values done");

      for (int n = 0; n < 80; n++)
      begin
         r = {$urandom, $urandom};
         s = $urandom % 2;
         if ($urandom % 2)
            cfg(1'(r[63]), 8'h58 + 8'(8*($urandom % 6)),
                r & ~64'h400);
         else
            acc(1'(s), ((r[39:0] & ~expReg[2*s+1][39:0]) |
                (expReg[2*s][39:0] & expReg[2*s+1][39:0])) ^
                (40'h1 << ($urandom % 40)));
      end
      $display("test random_traffic done");

      b = 40'({$urandom, $urandom}) & 40'hFF_FFE0_0000;
      seg_run(0, b | 40'h40_0000_0000, 40'h00_0020_0000);
      $display("test check_segment done");
      sz = 40'h1 << (19 + $urandom % 8);
      b  = 40'({$urandom, $urandom}) & ~(sz - 40'h1) & 40'hFF_FFF8_0000;
      seg_run(1, b, sz);
      $display("test stolen_segment done");

      for (s = 0; s < 2; s++)
      begin
         cfg(1'b1, 8'h68 + 8'(16*s), expReg[2*s+1] | 64'h400);
         cfg(1'b1, 8'h60 + 8'(16*s), {$urandom, $urandom});
         cfg(1'b1, 8'h68 + 8'(16*s), 64'h0000_0000_0000_0000);
         cfg(1'b0, 8'h60 + 8'(16*s), '0);
         cfg(1'b0, 8'h68 + 8'(16*s), '0);
         acc(1'(s), expReg[2*s][39:0]);
      end
      do_reset();
      for (int k = 0; k < 4; k++) cfg(1'b0, 8'h60 + 8'(8*k), '0);
      $display("test lock_and_reset done");
      give_verdict();
   end

   initial
   begin
      #500_000;
      error_cnt++;
      $display("watchdog expired");
      give_verdict();
   end
endmodule : test_protected_range_decoder

// [design/prd_decoder.sv]
// Purpose : Protected range decoder with two base/mask segments
// Assumes : Single clock, synchronous reset, one access per request
// Notes   : Answers and abort flags appear one cycle after the request
//
// Behaviour
// - Check base holds bits 39:19, 512KB aligned
// - Enabled check segment aborts chipset hits, raises check
// - Check lock freezes base and mask until reset
// - Stolen base holds bits 39:19, 512KB aligned
// - Stolen mask selects which bits must match
// - Enabled stolen segment aborts core hits
// - Stolen mask bit 10 shows lock state
// - Each range register is one 64-bit quadword
module prd_decoder
   import prd_pkg::*;
#(
   parameter int ADDR_W = PRD_ADDR_W
)
(
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   input  wire logic                  cfgReq,
   input  wire logic                  cfgWrite,
   input  wire logic [7:0]            cfgOffset,
   input  wire logic [PRD_REG_W-1:0]  cfgWdata,
   output logic                       cfgAck,
   output logic      [PRD_REG_W-1:0]  cfgRdata,
   input  wire logic                  chipReq,
   input  wire logic [ADDR_W-1:0]     chipAddr,
   output logic                       chipDone,
   output logic                       chipAbort,
   output logic                       machineCheck,
   input  wire logic                  coreReq,
   input  wire logic [ADDR_W-1:0]     coreAddr,
   output logic                       coreDone,
   output logic                       coreAbort
);

   ////////////////////////////////////////////////////////////////////////
   // Elaboration check: the range fields need the full physical width
   if (ADDR_W != PRD_ADDR_W)
   begin : g_bad_width
      $error("prd_decoder: ADDR_W must equal the 40-bit field layout");
   end

   ////////////////////////////////////////////////////////////////////////
   // Register decode
   prd_sel_e                sel;
   logic                    wrChkBase;
   logic                    wrChkMask;
   logic                    wrStlBase;
   logic                    wrStlMask;

   logic [PRD_FIELD_W-1:0]  chkBase;
   logic [PRD_FIELD_W-1:0]  chkMask;
   logic                    chkEnable;
   logic                    chkLock;
   logic                    chkHit;
   logic [PRD_FIELD_W-1:0]  stlBase;
   logic [PRD_FIELD_W-1:0]  stlMask;
   logic                    stlEnable;
   logic                    stlLock;
   logic                    stlHit;

   // Offsets are quadword slots; a partial offset is simply unmapped
   assign sel       = prd_decode(cfgOffset);
   assign wrChkBase = cfgReq && cfgWrite && (sel == PRD_SEL_CHK_BASE);
   assign wrChkMask = cfgReq && cfgWrite && (sel == PRD_SEL_CHK_MASK);
   assign wrStlBase = cfgReq && cfgWrite && (sel == PRD_SEL_STL_BASE);
   assign wrStlMask = cfgReq && cfgWrite && (sel == PRD_SEL_STL_MASK);

   ////////////////////////////////////////////////////////////////////////
   // Segments: machine-check segment faces the chipset side,
   // stolen segment faces the cores
   prd_segment u_check_segment
   (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .wrBase   (wrChkBase),
      .wrMask   (wrChkMask),
      .wdata    (cfgWdata),
      .addr     (chipAddr),
      .base     (chkBase),
      .mask     (chkMask),
      .enable   (chkEnable),
      .lock     (chkLock),
      .hit      (chkHit)
   );

   prd_segment u_stolen_segment
   (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .wrBase   (wrStlBase),
      .wrMask   (wrStlMask),
      .wdata    (cfgWdata),
      .addr     (coreAddr),
      .base     (stlBase),
      .mask     (stlMask),
      .enable   (stlEnable),
      .lock     (stlLock),
      .hit      (stlHit)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read path
   function automatic logic [PRD_REG_W-1:0] prd_pack_base
      (input logic [PRD_FIELD_W-1:0] b);
      logic [PRD_REG_W-1:0] v;
      v = PRD_RDATA_RST;
      v[PRD_FIELD_HI:PRD_FIELD_LO] = b;
      return v;
   endfunction : prd_pack_base

   function automatic logic [PRD_REG_W-1:0] prd_pack_mask
      (input logic [PRD_FIELD_W-1:0] m, input logic en, input logic lk);
      logic [PRD_REG_W-1:0] v;
      v = PRD_RDATA_RST;
      v[PRD_FIELD_HI:PRD_FIELD_LO] = m;
      v[PRD_ENABLE_B] = en;
      v[PRD_LOCK_B]   = lk;
      return v;
   endfunction : prd_pack_mask

   logic                  cfgAck_q;
   logic                  cfgAck_d;
   logic [PRD_REG_W-1:0]  cfgRdata_q;
   logic [PRD_REG_W-1:0]  cfgRdata_d;

   always_comb
   begin
      cfgAck_d   = cfgReq;
      cfgRdata_d = PRD_RDATA_RST;
      // Writes answer with zero data; reserved bits always read zero
      if (cfgReq && !cfgWrite)
      begin
         unique case (sel)
            PRD_SEL_CHK_BASE: cfgRdata_d = prd_pack_base(chkBase);
            PRD_SEL_CHK_MASK:
               cfgRdata_d = prd_pack_mask(chkMask, chkEnable, chkLock);
            PRD_SEL_STL_BASE: cfgRdata_d = prd_pack_base(stlBase);
            PRD_SEL_STL_MASK:
               cfgRdata_d = prd_pack_mask(stlMask, stlEnable, stlLock);
            PRD_SEL_NONE:     cfgRdata_d = PRD_RDATA_RST;
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         cfgAck_q   <= 1'b0;
         cfgRdata_q <= PRD_RDATA_RST;
      end
      else
      begin
         cfgAck_q   <= cfgAck_d;
         cfgRdata_q <= cfgRdata_d;
      end
   end

   assign cfgAck   = cfgAck_q;
   assign cfgRdata = cfgRdata_q;

   ////////////////////////////////////////////////////////////////////////
   // Access checking: verdicts are registered so every output is a flop;
   // the cost is one cycle of latency on each access
   logic chipDone_q;
   logic chipDone_d;
   logic chipAbort_q;
   logic chipAbort_d;
   logic machineCheck_q;
   logic machineCheck_d;
   logic coreDone_q;
   logic coreDone_d;
   logic coreAbort_q;
   logic coreAbort_d;

   always_comb
   begin
      chipDone_d     = chipReq;
      chipAbort_d    = chipReq && chkHit;
      machineCheck_d = chipReq && chkHit;
      coreDone_d     = coreReq;
      coreAbort_d    = coreReq && stlHit;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         chipDone_q     <= 1'b0;
         chipAbort_q    <= 1'b0;
         machineCheck_q <= 1'b0;
         coreDone_q     <= 1'b0;
         coreAbort_q    <= 1'b0;
      end
      else
      begin
         chipDone_q     <= chipDone_d;
         chipAbort_q    <= chipAbort_d;
         machineCheck_q <= machineCheck_d;
         coreDone_q     <= coreDone_d;
         coreAbort_q    <= coreAbort_d;
      end
   end

   assign chipDone     = chipDone_q;
   assign chipAbort    = chipAbort_q;
   assign machineCheck = machineCheck_q;
   assign coreDone     = coreDone_q;
   assign coreAbort    = coreAbort_q;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   AST_CHIP_ABORT_HIT: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      chipReq && chkEnable &&
      (((chipAddr[PRD_FIELD_HI:PRD_FIELD_LO] ^ chkBase) & chkMask) == '0)
      |=> chipAbort && machineCheck)
      else $error("Chipset hit in check segment not aborted");

   AST_CHIP_NO_ABORT: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      !(chipReq && chkEnable) |=> !chipAbort && !machineCheck)
      else $error("Abort without enabled chipset access");

   AST_CORE_ABORT_HIT: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      coreReq && stlEnable &&
      (((coreAddr[PRD_FIELD_HI:PRD_FIELD_LO] ^ stlBase) & stlMask) == '0)
      |=> coreAbort)
      else $error("Core hit in stolen segment not aborted");

   AST_CORE_MISS: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      coreReq &&
      (((coreAddr[PRD_FIELD_HI:PRD_FIELD_LO] ^ stlBase) & stlMask) != '0)
      |=> coreDone && !coreAbort)
      else $error("Core miss aborted");

   AST_MASK_READBACK: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      cfgReq && !cfgWrite && cfgOffset == PRD_OFF_STL_MASK
      |=> cfgAck && cfgRdata[PRD_LOCK_B] == $past(stlLock)
      && cfgRdata[PRD_ENABLE_B] == $past(stlEnable))
      else $error("Stolen mask readback wrong");

   AST_BASE_RESERVED_ZERO: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      cfgReq && !cfgWrite && cfgOffset == PRD_OFF_CHK_BASE
      |=> cfgRdata[PRD_FIELD_LO-1:0] == '0
      && cfgRdata[PRD_FIELD_HI:PRD_FIELD_LO] == $past(chkBase))
      else $error("Check base readback wrong");

   AST_LOCKED_WRITE_IGNORED: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      stlLock && wrStlBase |=> $stable(stlBase))
      else $error("Locked stolen base changed");

   AST_ACK_ONE_CYCLE: assert property (@(posedge core_clk)
      disable iff (!rst_n) cfgAck == $past(cfgReq))
      else $error("Config answer not one cycle later");

   // Verdict strobes are single pulses; a stuck strobe would double count
   AST_CHIP_DONE_PULSE: assert property (@(posedge core_clk)
      disable iff (!rst_n) chipDone == $past(chipReq))
      else $error("Chipset verdict not one cycle after request");

   AST_CORE_DONE_PULSE: assert property (@(posedge core_clk)
      disable iff (!rst_n) coreDone == $past(coreReq))
      else $error("Core verdict not one cycle after request");

   AST_WRITE_READS_ZERO: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      cfgReq && cfgWrite |=> cfgRdata == '0)
      else $error("Write answered with nonzero data");

   AST_CORE_NO_ABORT: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      !(coreReq && stlEnable) |=> !coreAbort)
      else $error("Core abort without enabled core access");

   AST_CHIP_MISS: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      chipReq &&
      (((chipAddr[PRD_FIELD_HI:PRD_FIELD_LO] ^ chkBase) & chkMask) != '0)
      |=> chipDone && !chipAbort && !machineCheck)
      else $error("Chipset miss aborted");

   COV_CHIP_ABORT: cover property (@(posedge core_clk)
      disable iff (!rst_n) machineCheck);
   COV_CORE_ABORT: cover property (@(posedge core_clk)
      disable iff (!rst_n) coreAbort);
   COV_LOCKED_WRITE: cover property (@(posedge core_clk)
      disable iff (!rst_n) chkLock && wrChkMask);
   COV_UNMAPPED_READ: cover property (@(posedge core_clk)
      disable iff (!rst_n) cfgReq && !cfgWrite && sel == PRD_SEL_NONE);
   COV_STOLEN_LOCKED_WRITE: cover property (@(posedge core_clk)
      disable iff (!rst_n) stlLock && wrStlBase);

endmodule : prd_decoder

// [design/prd_pkg.sv]
// Purpose : Shared constants for the protected range decoder
// Assumes : Quadword configuration accesses at fixed offsets
// Notes   : Field layout is identical for both protected segments
package prd_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Configuration offsets
   localparam logic [7:0] PRD_OFF_CHK_BASE = 8'h60;
   localparam logic [7:0] PRD_OFF_CHK_MASK = 8'h68;
   localparam logic [7:0] PRD_OFF_STL_BASE = 8'h70;
   localparam logic [7:0] PRD_OFF_STL_MASK = 8'h78;

   ////////////////////////////////////////////////////////////////////////
   // Field layout
   localparam int PRD_REG_W     = 64;
   localparam int PRD_ADDR_W    = 40;
   localparam int PRD_FIELD_HI  = 39;
   localparam int PRD_FIELD_LO  = 19;
   localparam int PRD_FIELD_W   = PRD_FIELD_HI - PRD_FIELD_LO + 1;
   localparam int PRD_ENABLE_B  = 11;
   localparam int PRD_LOCK_B    = 10;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [PRD_FIELD_W-1:0] PRD_FIELD_RST = 21'h00_0000;
   localparam logic [PRD_REG_W-1:0]   PRD_RDATA_RST =
      64'h0000_0000_0000_0000;

   ////////////////////////////////////////////////////////////////////////
   // Register selector
   typedef enum logic [2:0]
   {
      PRD_SEL_NONE     = 3'b000,
      PRD_SEL_CHK_BASE = 3'b001,
      PRD_SEL_CHK_MASK = 3'b010,
      PRD_SEL_STL_BASE = 3'b011,
      PRD_SEL_STL_MASK = 3'b100
   } prd_sel_e;

   function automatic prd_sel_e prd_decode(input logic [7:0] off);
      prd_sel_e sel;
      sel = PRD_SEL_NONE;
      unique case (off)
         PRD_OFF_CHK_BASE: sel = PRD_SEL_CHK_BASE;
         PRD_OFF_CHK_MASK: sel = PRD_SEL_CHK_MASK;
         PRD_OFF_STL_BASE: sel = PRD_SEL_STL_BASE;
         PRD_OFF_STL_MASK: sel = PRD_SEL_STL_MASK;
         default:          sel = PRD_SEL_NONE;
      endcase
      return sel;
   endfunction : prd_decode

endpackage : prd_pkg

// [design/prd_segment.sv]
// Purpose : One protected segment: base, mask, enable, lock and match
// Assumes : Writes arrive as whole quadwords from the top level
// Notes   : Lock freezes both registers until the next reset
module prd_segment
   import prd_pkg::*;
(
   input  wire logic                   core_clk,
   input  wire logic                   rst_n,
   input  wire logic                   wrBase,
   input  wire logic                   wrMask,
   input  wire logic [PRD_REG_W-1:0]   wdata,
   input  wire logic [PRD_ADDR_W-1:0]  addr,
   output logic      [PRD_FIELD_W-1:0] base,
   output logic      [PRD_FIELD_W-1:0] mask,
   output logic                        enable,
   output logic                        lock,
   output logic                        hit
);

   logic [PRD_FIELD_W-1:0] base_q;
   logic [PRD_FIELD_W-1:0] base_d;
   logic [PRD_FIELD_W-1:0] mask_q;
   logic [PRD_FIELD_W-1:0] mask_d;
   logic                   enable_q;
   logic                   enable_d;
   logic                   lock_q;
   logic                   lock_d;

   ////////////////////////////////////////////////////////////////////////
   // Register update
   always_comb
   begin
      base_d   = base_q;
      mask_d   = mask_q;
      enable_d = enable_q;
      lock_d   = lock_q;
      // Locked writes are dropped silently; the write that sets lock
      // still lands, so software can program and lock in one access
      if (!lock_q)
      begin
         if (wrBase)
         begin
            base_d = wdata[PRD_FIELD_HI:PRD_FIELD_LO];
         end
         if (wrMask)
         begin
            mask_d   = wdata[PRD_FIELD_HI:PRD_FIELD_LO];
            enable_d = wdata[PRD_ENABLE_B];
            lock_d   = wdata[PRD_LOCK_B];
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         base_q   <= PRD_FIELD_RST;
         mask_q   <= PRD_FIELD_RST;
         enable_q <= 1'b0;
         lock_q   <= 1'b0;
      end
      else
      begin
         base_q   <= base_d;
         mask_q   <= mask_d;
         enable_q <= enable_d;
         lock_q   <= lock_d;
      end
   end

   assign base   = base_q;
   assign mask   = mask_q;
   assign enable = enable_q;
   assign lock   = lock_q;
   // Masked compare of address bits against the base
   assign hit    = enable_q &&
      (((addr[PRD_FIELD_HI:PRD_FIELD_LO] ^ base_q) & mask_q) == '0);

   ////////////////////////////////////////////////////////////////////////
   // Checks
   AST_LOCK_HOLDS_BASE: assert property (@(posedge core_clk)
      disable iff (!rst_n) $past(lock_q) |-> $stable(base_q))
      else $error("Base changed while locked");

   AST_LOCK_HOLDS_MASK: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      $past(lock_q) |-> $stable(mask_q) && $stable(enable_q) && lock_q)
      else $error("Mask or lock changed while locked");

   AST_UNLOCKED_WRITE: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      !lock_q && wrBase |=> base_q == $past(wdata[PRD_FIELD_HI:PRD_FIELD_LO]))
      else $error("Unlocked base write lost");

endmodule : prd_segment
